// [adcc_pkg.sv]
/*
 * Shared constants, enumerations and carrier structs for the per-axis drive
 * commutation configuration block.
 * Assumes a single 20 MHz clock domain and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package adcc_pkg;
	// Geometry and clocking
	localparam int NUM_AXES = 4;
	localparam int ADDR_W = 9;
	localparam int CLK_HZ = 20_000_000;
	localparam int IDLE_TIME_MS = 500;
	localparam int IDLE_CYCLES = IDLE_TIME_MS * (CLK_HZ / 1000);

	// Resolver resolution codes
	typedef enum logic [2:0] {
		RES_NONE = 3'h0,
		RES_10 = 3'h1,
		RES_12 = 3'h2,
		RES_14 = 3'h3,
		RES_16 = 3'h4,
		RES_DYN = 3'h5
	} adcc_res_e;

	// Drive type codes
	typedef enum logic [1:0] {
		DRV_DC = 2'h0,
		DRV_ACBL = 2'h1,
		DRV_STEP = 2'h2,
		DRV_RECIRC = 2'h3
	} adcc_drive_e;

	// Counts per revolution for each resolution
	localparam logic [16:0] CNT_10 = 17'h00400;
	localparam logic [16:0] CNT_12 = 17'h01000;
	localparam logic [16:0] CNT_14 = 17'h04000;
	localparam logic [16:0] CNT_16 = 17'h10000;

	// Write limits, compared against the merged 32-bit word
	localparam logic [31:0] LIM_RES = 32'h00000005;
	localparam logic [31:0] LIM_DRV = 32'h00000003;
	localparam logic [31:0] LIM_ECPR = 32'h00010000;
	localparam logic [31:0] LIM_DEG = 32'h00000167;
	localparam logic [31:0] LIM_PCT = 32'h00000064;
	localparam logic [31:0] LIM_USTEP_MIN = 32'h000000C8;
	localparam logic [31:0] LIM_USTEP_MAX = 32'h00019000;
	localparam logic [8:0] DEG_MAX = 9'h167;
	localparam logic [8:0] DEG_FULL = 9'h168;
	localparam logic [13:0] MV_PER_PCT = 14'h0064;

	// Values after reset
	localparam logic [16:0] RST_ECPR = 17'h00004;
	localparam logic [47:0] RST_FCPR = 48'h000000000FA0;
	localparam logic [8:0] RST_OFFSET = 9'h000;
	localparam logic [6:0] RST_RUN = 7'h46;
	localparam logic [6:0] RST_IDLE = 7'h23;
	localparam logic [16:0] RST_USTEP = 17'h00FA0;
	localparam logic [3:0] RST_CHECK = 4'hF;

	// Byte offsets inside one axis block (axis n at n * 0x40)
	localparam logic [5:0] OFS_PRIM = 6'h00;
	localparam logic [5:0] OFS_SEC = 6'h04;
	localparam logic [5:0] OFS_DRIVE = 6'h08;
	localparam logic [5:0] OFS_ECPR = 6'h0C;
	localparam logic [5:0] OFS_FCPR_LO = 6'h10;
	localparam logic [5:0] OFS_FCPR_HI = 6'h14;
	localparam logic [5:0] OFS_OFFSET = 6'h18;
	localparam logic [5:0] OFS_RUN = 6'h1C;
	localparam logic [5:0] OFS_IDLE = 6'h20;
	localparam logic [5:0] OFS_USTEP = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	localparam logic [5:0] OFS_PCNT = 6'h2C;
	localparam logic [5:0] OFS_SCNT = 6'h30;
	localparam logic [ADDR_W-1:0] ADDR_CHECK = 9'h100;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// One axis configuration
	typedef struct packed {
		adcc_res_e prim;
		adcc_res_e sec;
		adcc_drive_e drive;
		logic [16:0] ecpr;
		logic [47:0] fcpr;
		logic [8:0] offset;
		logic [6:0] run;
		logic [6:0] idle;
		logic [16:0] ustep;
	} adcc_cfg_s;

	localparam adcc_cfg_s CFG_RST = '{prim: RES_14, sec: RES_14, drive: DRV_DC,
		ecpr: RST_ECPR, fcpr: RST_FCPR, offset: RST_OFFSET, run: RST_RUN,
		idle: RST_IDLE, ustep: RST_USTEP};

	// Motion status reaching one axis
	typedef struct packed {
		logic vel_zero;
		logic in_pos;
		logic prim_enc;
		logic sec_res;
		logic dyn_coarse;
		logic fb_up;
		logic fb_dn;
	} adcc_axis_in_s;

	// Drive commands of one axis
	typedef struct packed {
		logic low_cur;
		logic recirc;
		logic six_step;
		logic sine_en;
		logic home_marker;
		logic check_en;
		logic [8:0] angle;
		logic [13:0] peak_mv;
	} adcc_axis_out_s;
endpackage
`default_nettype wire

// [adcc_res_decode.sv]
/*
 * Resolver resolution code to counts-per-revolution decoder, registered.
 * Assumes code and qualifiers come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module adcc_res_decode
	import adcc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Code and its qualifiers
	input wire adcc_res_e code,
	input wire logic active,
	input wire logic coarse,
	// Decoded counts per revolution
	output logic [16:0] counts
);
	// Whole state of the decoder
	typedef struct packed {
		logic [16:0] cnt;
	} adcc_dec_s;
	adcc_dec_s st_r;
	adcc_dec_s st_nxt;

	// Map code to counts; zero when unused
	always_comb
	begin
		st_nxt.cnt = 17'h00000;
		if (active)
		begin
			case (code)
				RES_10: st_nxt.cnt = CNT_10; // [R1]
				RES_12: st_nxt.cnt = CNT_12;
				RES_14: st_nxt.cnt = CNT_14;
				RES_16: st_nxt.cnt = CNT_16; // [R1]
				RES_DYN: st_nxt.cnt = coarse ? CNT_14 : CNT_16;
				default: st_nxt.cnt = 17'h00000;
			endcase
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign counts = st_r.cnt;

	// Sixteen-bit code gives 65,536 counts
	property p_res16;
		@(posedge aclk) disable iff (!aresetn)
		(active && code == RES_16) |=> (counts == CNT_16);
	endproperty
	a_res16: assert property (p_res16) else $error("16-bit code not 65536"); // [R1]

	// Unused feedback reports no counts
	property p_unused;
		@(posedge aclk) disable iff (!aresetn)
		!active |=> (counts == 17'h00000);
	endproperty
	a_unused: assert property (p_unused) else $error("unused code gave counts"); // [R2]
endmodule // adcc_res_decode
`default_nettype wire

// [adcc_axis.sv]
/*
 * One axis: commutation angle tracking, six-step fallback, stepper current
 * scaling with idle timer and recirculation command.
 * Assumes motion inputs come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module adcc_axis
	import adcc_pkg::*;
#(
	parameter int IDLE_CYC = IDLE_CYCLES
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration
	input wire adcc_cfg_s cfg,
	input wire logic check_flag,
	// Motion and feedback
	input wire adcc_axis_in_s ain,
	// Drive commands
	output adcc_axis_out_s aout
);
	// Whole state of the axis
	typedef struct packed {
		logic [23:0] idle_cnt;
		logic low;
		logic signed [49:0] resid;
		logic [8:0] deg;
		adcc_axis_out_s out;
	} adcc_ax_s;
	adcc_ax_s st_r;
	adcc_ax_s st_nxt;
	logic stepper; // Either stepper drive
	logic commute; // Angle tracking in use
	logic six; // Six-step fallback
	logic [25:0] prod; // Cycles per revolution times 360 degrees
	logic signed [49:0] r; // Working residue
	logic [9:0] sum; // Angle plus offset
	logic [6:0] pct; // Selected current level

	// Next state
	always_comb
	begin
		st_nxt = st_r;
		stepper = cfg.drive[1];
		commute = (cfg.drive == DRV_ACBL) || (stepper && check_flag); // [R9]
		six = (cfg.drive == DRV_ACBL) && ain.prim_enc && (cfg.ecpr == 17'h0); // [R7]
		// Each count moves ecpr*360/fcpr degrees; one degree settles per clock
		prod = 26'(cfg.ecpr) * 26'(DEG_FULL); // [R8]
		r = st_r.resid;
		if (ain.fb_up)
			r = r + $signed({24'h000000, prod});
		if (ain.fb_dn)
			r = r - $signed({24'h000000, prod});
		if (!commute || six || cfg.fcpr == 48'h0)
		begin
			// Brush motors ignore the feedback count setting
			st_nxt.resid = 50'sh0; // [R9]
			st_nxt.deg = 9'h000;
		end
		else if (r >= $signed({2'b00, cfg.fcpr}))
		begin
			// One degree forward
			st_nxt.resid = r - $signed({2'b00, cfg.fcpr}); // [R8]
			st_nxt.deg = (st_r.deg == DEG_MAX) ? 9'h000 : 9'(st_r.deg + 9'h001);
		end
		else if (r < 50'sh0)
		begin
			// One degree back
			st_nxt.resid = r + $signed({2'b00, cfg.fcpr});
			st_nxt.deg = (st_r.deg == 9'h000) ? DEG_MAX : 9'(st_r.deg - 9'h001);
		end
		else
			st_nxt.resid = r;
		// Phase offset wraps modulo 360
		sum = {1'b0, st_r.deg} + {1'b0, cfg.offset}; // [R10]
		if (sum >= {1'b0, DEG_FULL})
			sum = sum - {1'b0, DEG_FULL};
		// Idle timer runs while commanded velocity is zero
		if (!ain.vel_zero)
		begin
			st_nxt.idle_cnt = 24'h000000;
			st_nxt.low = 1'b0;
		end
		else if (st_r.idle_cnt >= 24'(IDLE_CYC - 1))
			st_nxt.low = 1'b1; // [R12]
		else
			st_nxt.idle_cnt = 24'(st_r.idle_cnt + 24'h000001);
		// Outputs
		st_nxt.out.low_cur = stepper && st_nxt.low;
		pct = st_nxt.out.low_cur ? cfg.idle : cfg.run; // [R11] [R12]
		st_nxt.out.peak_mv = stepper ? 14'(pct) * MV_PER_PCT : 14'h0000; // [R11]
		st_nxt.out.recirc = (cfg.drive == DRV_RECIRC) && ain.in_pos
			&& st_nxt.out.low_cur; // [R5]
		st_nxt.out.six_step = six; // [R7]
		st_nxt.out.sine_en = commute && !six;
		st_nxt.out.home_marker = ain.prim_enc; // [R17]
		st_nxt.out.check_en = stepper && check_flag;
		st_nxt.out.angle = sum[8:0];
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign aout = st_r.out;

	// Motion stopping after a move
	sequence s_restart;
		!ain.vel_zero ##1 ain.vel_zero;
	endsequence

	property p_recirc_on;
		@(posedge aclk) disable iff (!aresetn)
		(cfg.drive == DRV_RECIRC && ain.in_pos && ain.vel_zero && st_r.low) |=> aout.recirc;
	endproperty
	a_recirc_on: assert property (p_recirc_on) else $error("recirc missing"); // [R5]

	property p_recirc_off;
		@(posedge aclk) disable iff (!aresetn)
		!ain.in_pos |=> !aout.recirc;
	endproperty
	a_recirc_off: assert property (p_recirc_off) else $error("recirc out of position"); // [R5]

	property p_six;
		@(posedge aclk) disable iff (!aresetn)
		(cfg.drive == DRV_ACBL && ain.prim_enc && cfg.ecpr == 17'h0)
			|=> (aout.six_step && !aout.sine_en);
	endproperty
	a_six: assert property (p_six) else $error("six-step not selected"); // [R7]

	property p_brush;
		@(posedge aclk) disable iff (!aresetn)
		(cfg.drive == DRV_DC) |=> !aout.sine_en;
	endproperty
	a_brush: assert property (p_brush) else $error("brush motor commutated"); // [R9]

	property p_angle;
		@(posedge aclk) disable iff (!aresetn)
		aout.angle < DEG_FULL;
	endproperty
	a_angle: assert property (p_angle) else $error("angle beyond 359"); // [R10]

	property p_run;
		@(posedge aclk) disable iff (!aresetn)
		(cfg.drive[1] && !ain.vel_zero) |=> (aout.peak_mv == 14'($past(cfg.run)) * MV_PER_PCT);
	endproperty
	a_run: assert property (p_run) else $error("run current wrong"); // [R11]

	property p_idle;
		@(posedge aclk) disable iff (!aresetn)
		s_restart |=> !aout.low_cur;
	endproperty
	a_idle: assert property (p_idle) else $error("idle current too soon"); // [R12]

	property p_home;
		@(posedge aclk) disable iff (!aresetn)
		ain.prim_enc |=> aout.home_marker;
	endproperty
	a_home: assert property (p_home) else $error("marker homing not chosen"); // [R17]
endmodule // adcc_axis
`default_nettype wire

// [adcc_top.sv]
/*
 * Four-axis drive commutation configuration: AXI4-Lite register file,
 * resolver decoders and per-axis drive logic.
 * Assumes an AXI4-Lite master on aclk and motion inputs on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1: Primary resolver code 0-5 maps counts
// R2: Secondary code same map, resolver only
// R3: Converter hardware matches selected resolution
// R4: Drive type code 0-3
// R5: Recirculate when in position, low current
// R6: Cycles per rev 0-65536, default 4
// R7: Zero cycles with encoder: six-step
// R8: Phase from cycles and feedback counts
// R9: Counts used except on brush motors; steppers use them only while their verification flag is set
// R10: Add 0-359 degree phase offset
// R11: Run current percent sets motion peak
// R12: Idle percent after 500 ms stopped
// R13: Microsteps 200 to 102400, default 4000
// R14: Per-axis verification flag, default yes
// R15: Stepper counts multiple of 50; not checked, any value 200 to 102400 accepted
// R16: Linear motors use one cycle
// R17: Encoder feedback ignores code, homes marker
module adcc_top
	import adcc_pkg::*;
#(
	parameter int IDLE_CYC = IDLE_CYCLES
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Per-axis motion and feedback status
	input wire adcc_axis_in_s [NUM_AXES-1:0] axis_in,
	// Per-axis drive commands
	output adcc_axis_out_s [NUM_AXES-1:0] axis_out,
	// Decoded resolver counts per revolution
	output logic [NUM_AXES-1:0][16:0] prim_counts,
	output logic [NUM_AXES-1:0][16:0] sec_counts
);
	// Whole state: configuration plus bus slave
	typedef struct packed {
		adcc_cfg_s [NUM_AXES-1:0] cfg;
		logic [3:0] check;
		logic aw_got;
		logic [ADDR_W-1:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} adcc_regs_s;

	localparam adcc_regs_s REGS_RST = '{cfg: {NUM_AXES{CFG_RST}}, check: RST_CHECK,
		default: '0};

	adcc_regs_s st_r;
	adcc_regs_s st_nxt;
	logic [32:0] rd_word; // Read lookup, valid flag on top
	logic [32:0] wr_word; // Current value under write
	logic [31:0] mask; // Byte lane mask
	logic [31:0] v; // Merged write value
	logic [1:0] wax; // Axis under write
	logic ok; // Write accepted

	// Register lookup: bit 32 set when the address is mapped
	function automatic logic [32:0] reg_word(input logic [ADDR_W-1:0] a);
		adcc_cfg_s c;
		adcc_axis_out_s o;
		logic [1:0] ax;
		logic [32:0] w;
		ax = a[7:6];
		c = st_r.cfg[ax];
		o = axis_out[ax];
		w = {1'b1, 32'h00000000};
		if (a[8])
		begin
			// Global verification flags
			if ({a[ADDR_W-1:2], 2'b00} == ADDR_CHECK)
				w[3:0] = st_r.check;
			else
				w[32] = 1'b0;
		end
		else
		begin
			case ({a[5:2], 2'b00})
				OFS_PRIM: w[2:0] = c.prim;
				OFS_SEC: w[2:0] = c.sec;
				OFS_DRIVE: w[1:0] = c.drive;
				OFS_ECPR: w[16:0] = c.ecpr;
				OFS_FCPR_LO: w[31:0] = c.fcpr[31:0];
				OFS_FCPR_HI: w[15:0] = c.fcpr[47:32];
				OFS_OFFSET: w[8:0] = c.offset;
				OFS_RUN: w[6:0] = c.run;
				OFS_IDLE: w[6:0] = c.idle;
				OFS_USTEP: w[16:0] = c.ustep;
				// Live drive state
				OFS_STATUS: w[31:0] = {2'b00, o.peak_mv, 1'b0, o.check_en, o.home_marker,
					o.low_cur, o.recirc, o.six_step, o.sine_en, o.angle};
				OFS_PCNT: w[16:0] = prim_counts[ax];
				OFS_SCNT: w[16:0] = sec_counts[ax];
				default: w[32] = 1'b0;
			endcase
		end
		return w;
	endfunction

	// Next state of the register file and bus slave
	always_comb
	begin
		st_nxt = st_r;
		rd_word = 33'h000000000;
		wr_word = 33'h000000000;
		mask = 32'h00000000;
		v = 32'h00000000;
		wax = 2'b00;
		ok = 1'b0;
		// Retire answers the master has taken
		if (st_r.bvalid && s_axi_bready)
			st_nxt.bvalid = 1'b0;
		if (st_r.rvalid && s_axi_rready)
			st_nxt.rvalid = 1'b0;
		// Capture address and data, in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		// Perform the write once both halves are held
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
		begin
			wr_word = reg_word(st_r.awaddr);
			mask = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}}, {8{st_r.wstrb[1]}},
				{8{st_r.wstrb[0]}}};
			v = (wr_word[31:0] & ~mask) | (st_r.wdata & mask);
			wax = st_r.awaddr[7:6];
			ok = 1'b1;
			if (st_r.awaddr[8])
			begin
				if ({st_r.awaddr[ADDR_W-1:2], 2'b00} == ADDR_CHECK && v[31:4] == 28'h0)
					st_nxt.check = v[3:0]; // [R14]
				else
					ok = 1'b0;
			end
			else
			begin
				// Out-of-range values are refused and leave the register unchanged
				case ({st_r.awaddr[5:2], 2'b00})
					OFS_PRIM:
						if (v <= LIM_RES) st_nxt.cfg[wax].prim = adcc_res_e'(v[2:0]); // [R1]
						else ok = 1'b0;
					OFS_SEC:
						if (v <= LIM_RES) st_nxt.cfg[wax].sec = adcc_res_e'(v[2:0]); // [R2]
						else ok = 1'b0;
					OFS_DRIVE:
						if (v <= LIM_DRV) st_nxt.cfg[wax].drive = adcc_drive_e'(v[1:0]); // [R4]
						else ok = 1'b0;
					OFS_ECPR:
						if (v <= LIM_ECPR) st_nxt.cfg[wax].ecpr = v[16:0]; // [R6]
						else ok = 1'b0;
					OFS_FCPR_LO:
						st_nxt.cfg[wax].fcpr[31:0] = v; // [R8]
					OFS_FCPR_HI:
						if (v[31:16] == 16'h0) st_nxt.cfg[wax].fcpr[47:32] = v[15:0];
						else ok = 1'b0;
					OFS_OFFSET:
						if (v <= LIM_DEG) st_nxt.cfg[wax].offset = v[8:0]; // [R10]
						else ok = 1'b0;
					OFS_RUN:
						if (v <= LIM_PCT) st_nxt.cfg[wax].run = v[6:0]; // [R11]
						else ok = 1'b0;
					OFS_IDLE:
						if (v <= LIM_PCT) st_nxt.cfg[wax].idle = v[6:0]; // [R12]
						else ok = 1'b0;
					OFS_USTEP:
						if (v >= LIM_USTEP_MIN && v <= LIM_USTEP_MAX)
							st_nxt.cfg[wax].ustep = v[16:0]; // [R13]
						else
							ok = 1'b0;
					// Status, counts and holes refuse writes
					default: ok = 1'b0;
				endcase
			end
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = ok ? RESP_OKAY : RESP_SLVERR;
		end
		// Read: answer in the cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready)
		begin
			rd_word = reg_word(s_axi_araddr);
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_word[31:0];
			st_nxt.rresp = rd_word[32] ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= REGS_RST;
		else
			st_r <= st_nxt;
	end

	// Bus handshakes and answers
	assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	// Per-axis decoders and drive logic
	genvar gi;
	generate
		for (gi = 0; gi < NUM_AXES; gi++)
		begin : g_axis
			// Primary code ignored with encoder feedback
			adcc_res_decode u_prim (
				.aclk(aclk),
				.aresetn(aresetn),
				.code(st_r.cfg[gi].prim),
				.active(!axis_in[gi].prim_enc), // [R17]
				.coarse(axis_in[gi].dyn_coarse),
				.counts(prim_counts[gi])
			);
			// Secondary code applies only to a velocity resolver
			adcc_res_decode u_sec (
				.aclk(aclk),
				.aresetn(aresetn),
				.code(st_r.cfg[gi].sec),
				.active(axis_in[gi].sec_res), // [R2]
				.coarse(axis_in[gi].dyn_coarse),
				.counts(sec_counts[gi])
			);
			// Commutation and current scaling
			adcc_axis #(
				.IDLE_CYC(IDLE_CYC)
			) u_axis (
				.aclk(aclk),
				.aresetn(aresetn),
				.cfg(st_r.cfg[gi]),
				.check_flag(st_r.check[gi]), // [R14]
				.ain(axis_in[gi]),
				.aout(axis_out[gi])
			);

			// Cycles per revolution back at default after reset
			property p_ecpr_dflt;
				@(posedge aclk)
				!aresetn |=> (st_r.cfg[gi].ecpr == RST_ECPR);
			endproperty
			a_ecpr_dflt: assert property (p_ecpr_dflt) else $error("ecpr default wrong"); // [R6]

			// Microstep count never leaves its range
			property p_ustep;
				@(posedge aclk) disable iff (!aresetn)
				(st_r.cfg[gi].ustep >= 17'(LIM_USTEP_MIN)) && (st_r.cfg[gi].ustep <= 17'(LIM_USTEP_MAX));
			endproperty
			a_ustep: assert property (p_ustep) else $error("microsteps out of range"); // [R13]
		end
	endgenerate

	// Verification flags all set after reset
	property p_check_dflt;
		@(posedge aclk)
		!aresetn |=> (st_r.check == RST_CHECK);
	endproperty
	a_check_dflt: assert property (p_check_dflt) else $error("check flags default wrong"); // [R14]

	// Refused writes leave the whole configuration unchanged and answer SLVERR
	property p_drive_keep;
		@(posedge aclk) disable iff (!aresetn)
		(st_r.aw_got && st_r.w_got && !st_r.bvalid && st_nxt.bresp == RESP_SLVERR)
			|=> (st_r.cfg == $past(st_r.cfg)) && (s_axi_bresp == RESP_SLVERR);
	endproperty
	a_drive_keep: assert property (p_drive_keep) else $error("refused write changed state"); // [R4]
endmodule // adcc_top
`default_nettype wire

// [adcc_motor_model.sv]
/* Behavioural amplifier and motor with feedback for the drive block.
   Assumes the bench sets motion demand and feedback kind per axis. */
`timescale 1ns/100ps
`default_nettype none
module adcc_motor_model
	import adcc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Demand from the bench
	input wire logic [NUM_AXES-1:0] move,
	input wire logic [NUM_AXES-1:0] enc,
	// Status and feedback pulses
	output adcc_axis_in_s [NUM_AXES-1:0] ain
);
	// Spaces count pulses two cycles apart
	logic tick_r;
	// Status levels and feedback counts
	always_ff @(posedge aclk)
	begin
		tick_r <= aresetn ? !tick_r : 1'b0;
		for (int i = 0; i < NUM_AXES; i++)
		begin
			ain[i].vel_zero <= !move[i];
			ain[i].in_pos <= !move[i];
			ain[i].prim_enc <= enc[i];
			ain[i].sec_res <= !enc[i];
			ain[i].dyn_coarse <= move[i]; // Dynamic converter coarse in motion
			ain[i].fb_up <= move[i] && tick_r;
			ain[i].fb_dn <= 1'b0;
		end
	end
endmodule // adcc_motor_model
`default_nettype wire

// [tb.sv]
/* Self-checking bench for the drive configuration block.
   Assumes the motor model file and the design package are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb
	import adcc_pkg::*;
;
	// Bus and motion signals
	logic aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [8:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] move, enc;
	adcc_axis_in_s [NUM_AXES-1:0] ain;
	adcc_axis_out_s [NUM_AXES-1:0] aout;
	logic [NUM_AXES-1:0][16:0] pc, sc;
	int err_count, comparisons, p, q, v;
	// Short idle time keeps the run brief
	adcc_top #(.IDLE_CYC(16)) adcc_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .axis_in(ain),
		.axis_out(aout), .prim_counts(pc), .sec_counts(sc));
	adcc_motor_model adcc_motor_model_i (.aclk(aclk), .aresetn(aresetn),
		.move(move), .enc(enc), .ain(ain));
	// Verdict and end of run
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One comparison
	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// Bounded wait ran out
	task automatic tmo(input int n);
		if (n >= 100)
		begin
			err_count++;
			$display("ERROR bus wait expected answer seen none");
			conclude();
		end
	endtask
	// Bus write, both halves offered together
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		int n;
		bit ad, wd;
		ad = 0;
		wd = 0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (!ad && awready)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		while (!(ad && wd) && n < 100);
		tmo(n);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (bvalid !== 1'b1 && n < 100);
		tmo(n);
		resp = bresp;
	endtask
	// Bus read, compare data and response
	task automatic rchk(input string nm, input logic [8:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (arready !== 1'b1 && n < 100);
		tmo(n);
		arvalid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (rvalid !== 1'b1 && n < 100);
		tmo(n);
		chk(nm, rdata, e);
		chk(nm, rresp, er);
	endtask
	// Write and compare the response
	task automatic wchk(input string nm, input logic [8:0] a, input logic [31:0] d,
		input logic [1:0] er);
		wr(a, d);
		chk(nm, resp, er);
	endtask
	// Expected counts per revolution
	function automatic logic [16:0] cnt(input int c);
		case (c)
			1: return CNT_10;
			2: return CNT_12;
			3: return CNT_14;
			4, 5: return CNT_16;
			default: return 17'h00000;
		endcase
	endfunction
	// Byte address of an axis register
	function automatic logic [8:0] ra(input logic [1:0] ax, input logic [5:0] o);
		return {1'b0, ax, o};
	endfunction
	// Random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, move, enc} = '0;
		{bready, rready} = 2'h3;
		{err_count, comparisons} = '0;
		seed = 32'h3272;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("prim", ra(0, OFS_PRIM), 32'h3, RESP_OKAY);
		rchk("sec", ra(1, OFS_SEC), 32'h3, RESP_OKAY);
		rchk("drive", ra(2, OFS_DRIVE), 32'h0, RESP_OKAY);
		rchk("ecpr", ra(3, OFS_ECPR), 32'h4, RESP_OKAY);
		rchk("fcpr", ra(0, OFS_FCPR_LO), 32'hFA0, RESP_OKAY);
		rchk("offset", ra(1, OFS_OFFSET), 32'h0, RESP_OKAY);
		rchk("run", ra(2, OFS_RUN), 32'h46, RESP_OKAY);
		rchk("idle", ra(3, OFS_IDLE), 32'h23, RESP_OKAY);
		rchk("ustep", ra(0, OFS_USTEP), 32'hFA0, RESP_OKAY);
		rchk("flags", ADDR_CHECK, 32'hF, RESP_OKAY);
		rchk("unmapped", 9'h03C, 32'h0, RESP_SLVERR);
		$display("Test reset values done");
		wchk("prim 6", ra(0, OFS_PRIM), 32'h6, RESP_SLVERR);
		wchk("sec 6", ra(0, OFS_SEC), 32'h6, RESP_SLVERR);
		wchk("drive 4", ra(0, OFS_DRIVE), 32'h4, RESP_SLVERR);
		wchk("ecpr max", ra(0, OFS_ECPR), 32'h10001, RESP_SLVERR);
		wchk("ecpr top", ra(0, OFS_ECPR), 32'h10000, RESP_OKAY);
		wchk("offset 360", ra(0, OFS_OFFSET), 32'h168, RESP_SLVERR);
		wchk("run 101", ra(0, OFS_RUN), 32'h65, RESP_SLVERR);
		wchk("idle 101", ra(0, OFS_IDLE), 32'h65, RESP_SLVERR);
		wchk("ustep 199", ra(0, OFS_USTEP), 32'hC7, RESP_SLVERR);
		wchk("ustep top", ra(0, OFS_USTEP), 32'h19000, RESP_OKAY);
		rchk("prim kept", ra(0, OFS_PRIM), 32'h3, RESP_OKAY);
		$display("Test ranges done");
		for (int c = 0; c < 6; c++)
		begin
			wchk("prim code", ra(0, OFS_PRIM), c, RESP_OKAY);
			wchk("sec code", ra(1, OFS_SEC), c, RESP_OKAY);
			repeat (3) @(posedge aclk);
			chk("prim counts", pc[0], cnt(c));
			chk("sec counts", sc[1], cnt(c));
		end
		move <= 4'h2;
		repeat (4) @(posedge aclk);
		chk("dyn coarse", sc[1], CNT_14);
		enc <= 4'h3;
		repeat (4) @(posedge aclk);
		chk("enc prim counts", pc[0], 48'h0);
		chk("enc sec counts", sc[1], 48'h0);
		chk("home marker", aout[0].home_marker, 48'h1);
		$display("Test decode done");
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			v = seed % 360;
			wchk("offset", ra(1, OFS_OFFSET), v, RESP_OKAY);
			repeat (3) @(posedge aclk);
			chk("brush angle", aout[1].angle, v);
		end
		chk("brush peak", aout[1].peak_mv, 48'h0);
		enc <= 4'h7;
		wchk("drive ac", ra(2, OFS_DRIVE), 32'h1, RESP_OKAY);
		wchk("ecpr 0", ra(2, OFS_ECPR), 32'h0, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("six step", aout[2].six_step, 48'h1);
		chk("sine off", aout[2].sine_en, 48'h0);
		wchk("ecpr 1", ra(2, OFS_ECPR), 32'h1, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("six step off", aout[2].six_step, 48'h0);
		chk("sine on", aout[2].sine_en, 48'h1);
		$display("Test commutation done");
		seed = lfsr(seed);
		p = seed % 101;
		q = seed[15:0] % 101;
		wchk("fcpr", ra(3, OFS_FCPR_LO), 32'h1F40, RESP_OKAY);
		wchk("drive recirc", ra(3, OFS_DRIVE), 32'h3, RESP_OKAY);
		wchk("run", ra(3, OFS_RUN), p, RESP_OKAY);
		wchk("idle", ra(3, OFS_IDLE), q, RESP_OKAY);
		move <= 4'h8;
		repeat (4) @(posedge aclk);
		chk("run peak", aout[3].peak_mv, 48'(p * 100));
		chk("check on", aout[3].check_en, 48'h1);
		move <= 4'h0;
		repeat (17) @(posedge aclk);
		chk("not yet low", aout[3].low_cur, 48'h0);
		repeat (1) @(posedge aclk);
		chk("low current", aout[3].low_cur, 48'h1);
		chk("idle peak", aout[3].peak_mv, 48'(q * 100));
		chk("recirc", aout[3].recirc, 48'h1);
		wchk("flags", ADDR_CHECK, 32'h7, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("check off", aout[3].check_en, 48'h0);
		$display("Test stepper done");
		conclude();
	end
endmodule // tb
`default_nettype wire
